/* File: design/dic_pkg.sv */
/*
 * Package for the deinterlacer control block: register offsets, field positions,
 * reset values, mode encodings and the packed carriers shared with the top module.
 * Assumes a 16-bit register port with byte offsets as printed and a 100 MHz system clock.
 */
package dic_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    localparam logic [11:0] OFS_IRQ_EN = 12'h114;
    localparam logic [11:0] OFS_SCALER = 12'h200;
    localparam logic [11:0] OFS_BUF_LO = 12'h400;
    localparam logic [11:0] OFS_BUF_HI = 12'h404;
    localparam logic [11:0] OFS_H_ACT = 12'h510;
    localparam logic [11:0] OFS_LINE_LEN = 12'h520;
    localparam logic [11:0] OFS_VBLANK = 12'h534;
    localparam logic [11:0] OFS_V_ACT = 12'h540;
    localparam logic [11:0] OFS_MODE = 12'h700;
    localparam logic [11:0] OFS_OUT_CFG = 12'h800;
    localparam logic [11:0] OFS_BYPASS = 12'h804;
    localparam logic [11:0] OFS_UPDATE = 12'h808;
    // Input configuration bits are held here because no other block owns them
    localparam logic [11:0] OFS_IN_CFG = 12'h010;

    localparam int BIT_VSYNC_IRQ = 0;
    localparam int BIT_HSYNC_IRQ = 1;
    localparam int BIT_SCALER_EN = 0;
    localparam int BIT_CONV_EN = 7;
    localparam int BIT_OUT_POL = 1;
    localparam int BIT_LINE_VALID = 0;
    localparam int BIT_BYPASS = 1;
    localparam int BIT_ITU_SEL = 4;
    localparam int BIT_HS_POL = 2;
    localparam int BIT_VS_POL = 1;

    localparam logic [15:0] RST_IRQ_EN = 16'h0000;
    localparam logic [15:0] RST_SCALER = 16'h0001;
    localparam logic [9:0] RST_H_ACT = 10'h280;
    localparam logic [9:0] RST_LINE_LEN = 10'h2da;
    localparam logic [5:0] RST_VBLANK = 6'h01;
    localparam logic [9:0] RST_V_ACT = 10'h1e0;
    localparam logic [15:0] RST_MODE = 16'h0080;
    localparam logic [15:0] RST_OUT_CFG = 16'h0003;
    localparam logic [15:0] RST_BYPASS = 16'h0000;
    localparam logic [15:0] RST_IN_CFG = 16'h0000;
    localparam logic [15:0] RST_BUF = 16'h0000;
    localparam logic [1:0] UPDATE_GO = 2'b11;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;

    typedef enum logic [1:0] {
        DI_WEAVE = 2'b00,
        DI_BOB = 2'b01,
        DI_INTERP = 2'b10,
        DI_RSVD = 2'b11
    } dic_di_mode_t;

    typedef enum logic [2:0] {
        UPD_IDLE = 3'b001,
        UPD_ARMED = 3'b010,
        UPD_APPLY = 3'b100
    } dic_upd_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dic_bus_req_t;

    // Settings that steer the conversion datapath
    typedef struct packed {
        logic scalerEn;
        logic conversionEn;
        dic_di_mode_t diMode;
        logic outSyncPolarity;
        logic lineValidSel;
        logic correctionBypassBit;
        logic [31:0] bufferStartAddress;
        logic [9:0] hActiveCount;
        logic [9:0] lineLength;
        logic [5:0] vblankLines;
        logic [9:0] vActiveCount;
    } dic_cfg_t;

    // Raw sync taps: pins for parallel sync, decoded code bits for embedded sync
    typedef struct packed {
        logic lineSyncIn;
        logic frameSyncIn;
        logic embHBit;
        logic embVBit;
    } dic_sync_t;
endpackage

/* File: design/dic_ctrl.sv */
/*
 * Register file and sync-edge interrupt logic of the deinterlacer control block.
 * Assumes a single-cycle register master, sync inputs synchronous to clk, and
 * a frame-start pulse from the conversion datapath.
 */
// Function
// - Horizontal sync trailing edge raises interrupt when its enable bit is set.
// - Vertical sync trailing edge raises interrupt when its enable bit is set.
// - Scaler enable resets to one; software leaves settings alone while set.
// - Buffer start address built from low bits 15:2 and high bits 31:16.
// - Ten-bit horizontal active pixel count, default 640.
// - Six-bit vertical blanking line count, default one.
// - Ten-bit vertical active line count, default 480.
// - Conversion enable resets to one; software keeps it enabled.
// - Two-bit deinterlace mode: weave, line double, interpolate; 11 reserved.
// - Output polarity bit: zero positive, one negative, reset one.
// - Horizontal sync type: zero pulse, one line valid strobe, reset one.
// - Bypass bit routes video around image correction when set.
// - Writing 11 to update applies correction settings from next frame.
// - Input standard select chooses parallel pins or embedded codes.
// - Input sync polarity bits select low or high active; ignored embedded.
module dic_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire dic_pkg::dic_bus_req_t busReq,
    output logic [15:0] rdData,
    input wire dic_pkg::dic_sync_t syncIn,
    input wire logic frameStart,
    output dic_pkg::dic_cfg_t cfg,
    output logic correctionUpdate,
    output logic hsyncIrq,
    output logic vsyncIrq,
    output logic inputStandardSel
);
    import dic_pkg::*;

    logic rstMeta_ff;
    logic rstSync_ff;
    logic rstLocal_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end
    assign rstLocal_b = rstSync_ff;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    logic [15:0] irqEn_ff;
    logic [15:0] scaler_ff;
    logic [15:0] bufLo_ff;
    logic [15:0] bufHi_ff;
    logic [9:0] hAct_ff;
    logic [9:0] lineLen_ff;
    logic [5:0] vblank_ff;
    logic [9:0] vAct_ff;
    logic [15:0] mode_ff;
    logic [15:0] outCfg_ff;
    logic [15:0] bypass_ff;
    logic [15:0] inCfg_ff;
    logic [1:0] update_ff;
    logic [15:0] rdData_ff;

    wire logic wrEn = clkEn & busReq.wr;
    wire logic rdEn = clkEn & busReq.rd;
    wire logic [11:0] a = busReq.addr;
    wire logic [15:0] wd = busReq.wdata;

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            irqEn_ff <= RST_IRQ_EN;
            scaler_ff <= RST_SCALER;
            bufLo_ff <= RST_BUF;
            bufHi_ff <= RST_BUF;
            hAct_ff <= RST_H_ACT;
            lineLen_ff <= RST_LINE_LEN;
            vblank_ff <= RST_VBLANK;
            vAct_ff <= RST_V_ACT;
            mode_ff <= RST_MODE;
            outCfg_ff <= RST_OUT_CFG;
            bypass_ff <= RST_BYPASS;
            inCfg_ff <= RST_IN_CFG;
        end else if (wrEn) begin
            if (hit(a, OFS_IRQ_EN)) irqEn_ff <= {14'h0000, wd[1:0]};
            if (hit(a, OFS_SCALER)) scaler_ff <= {15'h0000, wd[BIT_SCALER_EN]};
            if (hit(a, OFS_BUF_LO)) bufLo_ff <= {wd[15:2], 2'b00};
            if (hit(a, OFS_BUF_HI)) bufHi_ff <= wd;
            if (hit(a, OFS_H_ACT)) hAct_ff <= wd[9:0];
            if (hit(a, OFS_LINE_LEN)) lineLen_ff <= wd[9:0];
            if (hit(a, OFS_VBLANK)) vblank_ff <= wd[5:0];
            if (hit(a, OFS_V_ACT)) vAct_ff <= wd[9:0];
            if (hit(a, OFS_MODE)) mode_ff <= {8'h00, wd[7], 5'h00, wd[1:0]};
            if (hit(a, OFS_OUT_CFG)) outCfg_ff <= {14'h0000, wd[1:0]};
            if (hit(a, OFS_BYPASS)) bypass_ff <= {14'h0000, wd[1], 1'b0};
            if (hit(a, OFS_IN_CFG)) inCfg_ff <= {11'h000, wd[4], 1'b0, wd[2:1], 1'b0};
        end
    end

    // Update request: armed by writing 11, delivered at the next frame start
    dic_upd_state_t upd_ff;
    dic_upd_state_t nxt_upd;
    wire logic updWrite = wrEn & hit(a, OFS_UPDATE) & (wd[1:0] == UPDATE_GO);

    always_comb begin
        case (upd_ff)
            UPD_IDLE: nxt_upd = updWrite ? UPD_ARMED : UPD_IDLE;
            UPD_ARMED: nxt_upd = frameStart ? UPD_APPLY : UPD_ARMED;
            UPD_APPLY: nxt_upd = updWrite ? UPD_ARMED : UPD_IDLE;
            default: nxt_upd = UPD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            upd_ff <= UPD_IDLE;
            update_ff <= 2'b00;
        end else if (clkEn) begin
            upd_ff <= nxt_upd;
            // Readback shows 11 while a request waits for its frame
            update_ff <= (nxt_upd == UPD_ARMED) ? UPDATE_GO : 2'b00;
        end
    end
    assign correctionUpdate = (upd_ff == UPD_APPLY);

    // Sync edge detection; inputs are synchronous so one stage suffices
    wire logic itu = inCfg_ff[BIT_ITU_SEL];
    wire logic hsync_in_polarity = inCfg_ff[BIT_HS_POL];
    wire logic vsync_in_polarity = inCfg_ff[BIT_VS_POL];
    // Fold pin polarity so the trailing edge is always a one-to-zero of "active"
    wire logic hActive = itu ? syncIn.embHBit : (syncIn.lineSyncIn ~^ hsync_in_polarity);
    wire logic vActive = itu ? syncIn.embVBit : (syncIn.frameSyncIn ~^ vsync_in_polarity);
    logic hPrev_ff;
    logic vPrev_ff;
    logic hsyncIrq_ff;
    logic vsyncIrq_ff;
    wire logic hTrail = hPrev_ff & ~hActive;
    wire logic vTrail = vPrev_ff & ~vActive;

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            hPrev_ff <= 1'b0;
            vPrev_ff <= 1'b0;
            hsyncIrq_ff <= 1'b0;
            vsyncIrq_ff <= 1'b0;
        end else if (clkEn) begin
            hPrev_ff <= hActive;
            vPrev_ff <= vActive;
            hsyncIrq_ff <= hTrail & irqEn_ff[BIT_HSYNC_IRQ];
            vsyncIrq_ff <= vTrail & irqEn_ff[BIT_VSYNC_IRQ];
        end
    end
    assign hsyncIrq = hsyncIrq_ff;
    assign vsyncIrq = vsyncIrq_ff;
    assign inputStandardSel = itu;

    // Read mux, registered for next-cycle data
    logic [15:0] rdMux;
    always_comb begin
        case (a)
            OFS_IRQ_EN: rdMux = irqEn_ff;
            OFS_SCALER: rdMux = scaler_ff;
            OFS_BUF_LO: rdMux = bufLo_ff;
            OFS_BUF_HI: rdMux = bufHi_ff;
            OFS_H_ACT: rdMux = {6'h00, hAct_ff};
            OFS_LINE_LEN: rdMux = {6'h00, lineLen_ff};
            OFS_VBLANK: rdMux = {10'h000, vblank_ff};
            OFS_V_ACT: rdMux = {6'h00, vAct_ff};
            OFS_MODE: rdMux = mode_ff;
            OFS_OUT_CFG: rdMux = outCfg_ff;
            OFS_BYPASS: rdMux = bypass_ff;
            OFS_UPDATE: rdMux = {14'h0000, update_ff};
            OFS_IN_CFG: rdMux = inCfg_ff;
            default: rdMux = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            rdData_ff <= 16'h0000;
        end else if (clkEn) begin
            rdData_ff <= rdEn ? rdMux : 16'h0000;
        end
    end
    assign rdData = rdData_ff;

    assign cfg.scalerEn = scaler_ff[BIT_SCALER_EN];
    assign cfg.conversionEn = mode_ff[BIT_CONV_EN];
    assign cfg.diMode = dic_di_mode_t'(mode_ff[1:0]);
    assign cfg.outSyncPolarity = outCfg_ff[BIT_OUT_POL];
    assign cfg.lineValidSel = outCfg_ff[BIT_LINE_VALID];
    assign cfg.correctionBypassBit = bypass_ff[BIT_BYPASS];
    assign cfg.bufferStartAddress = {bufHi_ff, bufLo_ff[15:2], 2'b00};
    assign cfg.hActiveCount = hAct_ff;
    assign cfg.lineLength = lineLen_ff;
    assign cfg.vblankLines = vblank_ff;
    assign cfg.vActiveCount = vAct_ff;

    // Checks
    chk_hirq_edge: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && hTrail && irqEn_ff[BIT_HSYNC_IRQ] |=> hsyncIrq)
        else $error("hsync interrupt missing after trailing edge");
    chk_virq_edge: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && vTrail && irqEn_ff[BIT_VSYNC_IRQ] |=> vsyncIrq)
        else $error("vsync interrupt missing after trailing edge");
    chk_irq_single_pulse: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && hsyncIrq && $stable(hActive) |=> !hsyncIrq)
        else $error("hsync interrupt longer than one edge");
    chk_virq_masked: assert property (@(posedge clk) disable iff (!rstLocal_b)
        $past(!irqEn_ff[BIT_VSYNC_IRQ]) |-> !vsyncIrq)
        else $error("vsync interrupt while disabled");
    chk_buf_addr_low: assert property (@(posedge clk) disable iff (!rstLocal_b)
        wrEn && hit(a, OFS_BUF_LO) |=> cfg.bufferStartAddress[15:0] == ($past(wd) & 16'hfffc))
        else $error("buffer address low half not word aligned copy of write");
    chk_update_frame: assert property (@(posedge clk) disable iff (!rstLocal_b)
        upd_ff == UPD_ARMED && clkEn && frameStart |=> correctionUpdate)
        else $error("update not applied at frame start");
    chk_update_wait: assert property (@(posedge clk) disable iff (!rstLocal_b)
        correctionUpdate |-> $past(upd_ff) == UPD_ARMED)
        else $error("update applied without request");
    chk_read_latency: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && busReq.rd && a == OFS_MODE |=> rdData == $past(mode_ff))
        else $error("mode readback mismatch");
    chk_mode_mask: assert property (@(posedge clk) disable iff (!rstLocal_b)
        mode_ff[6:2] == 5'h00 && mode_ff[15:8] == 8'h00)
        else $error("reserved mode bits set");
    chk_virq_single_pulse: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && vsyncIrq |=> !vsyncIrq)
        else $error("vsync interrupt longer than one edge");
    chk_hirq_masked: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && !irqEn_ff[BIT_HSYNC_IRQ] |=> !hsyncIrq)
        else $error("hsync interrupt while disabled");
    // Read data must not linger, software may poll the port freely
    chk_read_idle: assert property (@(posedge clk) disable iff (!rstLocal_b)
        clkEn && !busReq.rd |=> rdData == 16'h0000)
        else $error("read data outside its cycle");
    chk_freeze_state: assert property (@(posedge clk) disable iff (!rstLocal_b)
        !clkEn |=> $stable(cfg) && $stable(rdData) && $stable(upd_ff))
        else $error("state moved while clock enable low");
    cov_hirq: cover property (@(posedge clk) hsyncIrq);
    cov_virq_emb: cover property (@(posedge clk) vsyncIrq && itu);
    cov_update: cover property (@(posedge clk) correctionUpdate);
    cov_bypass: cover property (@(posedge clk) cfg.correctionBypassBit);
    cov_mode_interp: cover property (@(posedge clk) cfg.diMode == DI_INTERP);
endmodule

/* File: bench/dic_sync_src.sv */
/*
 * Camera-side sync source for the deinterlacer control bench.
 * Assumes one sync pulse is asked for at a time by a one-cycle go strobe.
 */
module dic_sync_src (
    input wire logic clk,
    input wire logic embMode,
    input wire logic hPol,
    input wire logic vPol,
    input wire logic hGo,
    input wire logic vGo,
    output dic_pkg::dic_sync_t syncIn
);
    timeunit 1ns;
    timeprecision 1ps;
    import dic_pkg::*;
    logic [1:0] hCnt = 2'h0;
    logic [1:0] vCnt = 2'h0;
    logic tog = 1'b0;
    wire hAct = hCnt != 2'h0;
    wire vAct = vCnt != 2'h0;
    always @(posedge clk) begin
        tog <= !tog;
        hCnt <= hGo ? 2'h3 : hCnt - {1'b0, hAct};
        vCnt <= vGo ? 2'h3 : vCnt - {1'b0, vAct};
    end
    // Unused taps toggle each cycle so a wrong source select shows as stray pulses
    assign syncIn.lineSyncIn = embMode ? tog : (hAct ~^ hPol);
    assign syncIn.frameSyncIn = embMode ? tog : (vAct ~^ vPol);
    assign syncIn.embHBit = embMode ? hAct : tog;
    assign syncIn.embVBit = embMode ? vAct : tog;
endmodule

/* File: bench/test_deinterlacer_control_regs.sv */
/*
 * Self-checking bench for the deinterlacer control block.
 * Assumes the sync source model beside it and a 100 MHz clock.
 */
module test_deinterlacer_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import dic_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic frameStart = 1'b0;
    logic embMode = 1'b0;
    logic hPol = 1'b0;
    logic vPol = 1'b0;
    logic hGo = 1'b0;
    logic vGo = 1'b0;
    dic_bus_req_t busReq = '0;
    dic_sync_t syncIn;
    dic_cfg_t cfg;
    logic [15:0] rdData;
    logic correctionUpdate, hsyncIrq, vsyncIrq, inputStandardSel;
    int miscompares = 0;
    int n_compared = 0;
    int nH, nV, nU, k;
    logic [15:0] seed = 16'h8b50;
    logic [15:0] d;
    logic [15:0] sh [13];
    logic [11:0] adr [13] = '{OFS_IRQ_EN, OFS_SCALER, OFS_BUF_LO, OFS_BUF_HI, OFS_H_ACT,
        OFS_LINE_LEN, OFS_VBLANK, OFS_V_ACT, OFS_MODE, OFS_OUT_CFG, OFS_BYPASS, OFS_UPDATE,
        OFS_IN_CFG};
    logic [15:0] msk [13] = '{16'h0003, 16'h0001, 16'hfffc, 16'hffff, 16'h03ff, 16'h03ff,
        16'h003f, 16'h03ff, 16'h0083, 16'h0003, 16'h0002, 16'h0003, 16'h0016};
    logic [15:0] rstv [13] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0280, 16'h02da,
        16'h0001, 16'h01e0, 16'h0080, 16'h0003, 16'h0000, 16'h0000, 16'h0000};

    always #5 clk = ~clk;

    dic_ctrl i_dic_ctrl (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .busReq(busReq),
        .rdData(rdData), .syncIn(syncIn), .frameStart(frameStart), .cfg(cfg),
        .correctionUpdate(correctionUpdate), .hsyncIrq(hsyncIrq), .vsyncIrq(vsyncIrq),
        .inputStandardSel(inputStandardSel));
    dic_sync_src i_dic_sync_src (.clk(clk), .embMode(embMode), .hPol(hPol), .vPol(vPol),
        .hGo(hGo), .vGo(vGo), .syncIn(syncIn));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic dic_cfg_t expCfg();
        dic_cfg_t e;
        e.scalerEn = sh[1][0];
        e.conversionEn = sh[8][7];
        e.diMode = dic_di_mode_t'(sh[8][1:0]);
        e.outSyncPolarity = sh[9][1];
        e.lineValidSel = sh[9][0];
        e.correctionBypassBit = sh[10][1];
        e.bufferStartAddress = {sh[3], sh[2][15:2], 2'b00};
        e.hActiveCount = sh[4][9:0];
        e.lineLength = sh[5][9:0];
        e.vblankLines = sh[6][5:0];
        e.vActiveCount = sh[7][9:0];
        return e;
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chkCfg(input dic_cfg_t got, input dic_cfg_t exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t settings got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkCnt(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            miscompares++;
            $display("BAD %0t %s pulses %0d want %0d", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic wsh(input int i, input logic [15:0] v);
        wr(adr[i], v);
        sh[i] = v & msk[i];
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [15:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk16(rdData, e, $sformatf("read %h", a));
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        hGo <= which == 0;
        vGo <= which == 1;
        frameStart <= which == 2;
        @(posedge clk);
        hGo <= 1'b0;
        vGo <= 1'b0;
        frameStart <= 1'b0;
    endtask
    task automatic count(input int n);
        nH = 0;
        nV = 0;
        nU = 0;
        repeat (n) begin
            #1;
            nH += int'(hsyncIrq === 1'b1);
            nV += int'(vsyncIrq === 1'b1);
            nU += int'(correctionUpdate === 1'b1);
            @(posedge clk);
        end
    endtask
    task automatic resetChk();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        sh = rstv;
        chkCfg(cfg, expCfg());
        for (int i = 0; i < 13; i++) rdChk(adr[i], rstv[i]);
        rdChk(12'h0fc, 16'h0000);
        $display("test reset done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        resetChk();
        // Scaler held off while the other settings change
        wsh(1, 16'h0000);
        for (int n = 0; n < 48; n++) begin
            seed = lfsr(seed);
            k = (n < 11) ? n : int'(seed[3:0]) % 11;
            k = (k == 1) ? 0 : k;
            d = (n < 11) ? 16'hffff : {seed[7:0], seed[15:8]};
            d[7] = (k == 8) ? 1'b1 : d[7];
            d = (k == 5) ? sh[4] + 16'h005a : d;
            wsh(k, d);
            rdChk(adr[k], sh[k]);
        end
        wr(12'h0fc, 16'hffff);
        rdChk(12'h0fc, 16'h0000);
        // Buffer parked near the top of the external DRAM window, 2 MB to spare
        wsh(3, 16'h4fe0);
        wsh(2, 16'h0000);
        wsh(1, 16'h0001);
        #1;
        chkCfg(cfg, expCfg());
        @(posedge clk);
        clkEn <= 1'b0;
        wr(OFS_BYPASS, ~sh[10]);
        @(posedge clk);
        clkEn <= 1'b1;
        rdChk(OFS_BYPASS, sh[10]);
        $display("test registers done");
        for (int i = 0; i < 32; i++) begin
            wsh(0, 16'h0000);
            wsh(12, {11'h000, i[0], 1'b0, i[1], i[2], 1'b0});
            embMode <= i[0];
            hPol <= i[1];
            vPol <= i[2];
            count(6);
            wsh(0, {14'h0000, i[4:3]});
            chk16({15'h0000, inputStandardSel}, {15'h0000, i[0]}, "standard");
            pulse(0);
            count(12);
            chkCnt(nH, int'(i[4]), "line");
            chkCnt(nV, 0, "frame");
            pulse(1);
            count(12);
            chkCnt(nV, int'(i[3]), "frame");
            chkCnt(nH, 0, "line");
        end
        $display("test interrupts done");
        for (int c = 0; c < 4; c++) begin
            wsh(11, c[1] ? 16'h0003 : 16'h0000);
            rdChk(OFS_UPDATE, sh[11]);
            count(6);
            chkCnt(nU, 0, "early update");
            pulse(2);
            count(6);
            chkCnt(nU, int'(c[1]), "update");
        end
        $display("test update done");
        resetChk();
        summarize();
    end

    // About 1650 cycles expected; roughly eighteen times that before giving up
    initial begin
        #300000;
        miscompares++;
        summarize();
    end
endmodule
